/* host_cpu_model.sv */
// Host processor model driving the three-level kick line
`timescale 1ns/10ps
module host_cpu_model (
  input  wire logic       i_mclk,      // Host clock
  input  wire logic [1:0] i_mode,      // 0 float, 1 low, 2 high, 3 toggle
  output logic            o_kick_low,  // Kick at valid low level
  output logic            o_kick_high  // Kick at valid high level
);
  logic [3:0] tick = 4'h0;  // Toggle spacing, 16 cycles
  logic       lvl  = 1'h0;  // Kick level while toggling
  // ---------------------------------------------------------------
  // Toggle timing
  // ---------------------------------------------------------------
  // kick within period
  always @(posedge i_mclk)
  begin
    tick <= tick + 4'h1;
    if (tick == 4'hF)
      lvl <= ~lvl;
  end
  // Floating leaves both level indications low
  assign o_kick_low  = (i_mode == 2'h1) | ((i_mode == 2'h3) & ~lvl);
  assign o_kick_high = (i_mode == 2'h2) | ((i_mode == 2'h3) & lvl);
endmodule : host_cpu_model

/* supervisor_pkg.sv */
// Constants shared by the supply supervisor and watchdog block
package supervisor_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;  // Clock rate
  localparam int unsigned RESET_ACTIVE_MS = 140;         // Least reset pulse, ms
  localparam int unsigned WDOG_PERIOD_MS  = 1600;        // Typical timeout, ms
  // Least time rounds up to whole cycles
  localparam longint unsigned RESET_ACTIVE_CYC =
    (longint'(RESET_ACTIVE_MS) * longint'(CLK_HZ) + 64'd999) / 64'd1000;
  // Typical time taken as is (exact in whole cycles)
  localparam longint unsigned WDOG_PERIOD_CYC =
    longint'(WDOG_PERIOD_MS) * longint'(CLK_HZ) / 64'd1000;
  // Counter width covering both counts
  localparam int unsigned CNT_W = 32;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic RST_N_RESET = 1'b0;  // System reset held at power-up
  localparam logic WDO_RESET   = 1'b1;  // Watchdog status idle high

endpackage : supervisor_pkg

/* supply_supervisor_watchdog.sv */
// Supply supervisor with a three-level watchdog and timed reset pulses
`timescale 1ns/10ps
module supply_supervisor_watchdog #(
  parameter longint unsigned RESET_CYC = supervisor_pkg::RESET_ACTIVE_CYC,
  parameter longint unsigned WDOG_CYC  = supervisor_pkg::WDOG_PERIOD_CYC
) (
  input  wire logic i_mclk,          // 50 MHz timebase
  input  wire logic i_nrst,          // Asynchronous reset, active low
  input  wire logic i_supply_low,    // Comparator: supply under threshold
  input  wire logic i_kick_low,      // Kick input at valid low level
  input  wire logic i_kick_high,     // Kick input at valid high level
  output logic      o_sys_reset_n,   // System reset, active low
  output logic      o_sys_reset,     // System reset, active high
  output logic      o_watchdog_expired_n  // Watchdog status, active low
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  if (RESET_CYC < 1 || RESET_CYC >= (64'd1 << supervisor_pkg::CNT_W))
  begin : g_bad_reset
    $error("RESET_CYC out of range");
  end
  if (WDOG_CYC < 2 || WDOG_CYC >= (64'd1 << supervisor_pkg::CNT_W))
  begin : g_bad_wdog
    $error("WDOG_CYC out of range");
  end
  // Pulses only separate when the period outlasts the pulse
  if (WDOG_CYC <= RESET_CYC)
  begin : g_bad_ratio
    $error("WDOG_CYC must exceed RESET_CYC");
  end

  localparam logic [supervisor_pkg::CNT_W-1:0] RST_LAST =
    supervisor_pkg::CNT_W'(RESET_CYC - 64'd1);
  localparam logic [supervisor_pkg::CNT_W-1:0] WDOG_LAST =
    supervisor_pkg::CNT_W'(WDOG_CYC - 64'd1);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic                              rst_n;     // Reset output level
    logic                              rst;       // Complement copy
    logic                              wdo_n;     // Watchdog status
    logic [supervisor_pkg::CNT_W-1:0]  hold_cnt;  // Reset stretch counter
    logic [supervisor_pkg::CNT_W-1:0]  wd_cnt;    // Watchdog counter
    logic                              last_lvl;  // Last valid kick level
    logic                              lvl_ok;    // last_lvl has been seen
  } state_t;

  state_t st;       // Registered state
  state_t next_st;  // Next value

  // Decoded kick: mid-level or floating when neither valid level shows
  logic kick_valid;  // At a valid level
  logic kick_lvl;    // Which valid level
  logic kick_edge;   // Service event this cycle
  logic wd_enabled;  // Watchdog running

  assign kick_valid = i_kick_low ^ i_kick_high;
  assign kick_lvl   = i_kick_high;
  assign kick_edge  = kick_valid && st.lvl_ok && (kick_lvl != st.last_lvl);
  assign wd_enabled = kick_valid;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Track last valid level; mid-level leaves it alone
    if (kick_valid)
    begin
      next_st.last_lvl = kick_lvl;
      next_st.lvl_ok   = 1'b1;
    end

    if (i_supply_low)
    begin
      next_st.rst_n    = 1'b0;
      next_st.hold_cnt = '0;
      next_st.wd_cnt   = '0;
      next_st.wdo_n    = 1'b1;
    end
    else if (!st.rst_n)
    begin
      if (st.hold_cnt == RST_LAST)
      begin
        next_st.rst_n    = 1'b1;
        next_st.hold_cnt = '0;
      end
      else
      begin
        next_st.hold_cnt = st.hold_cnt + 1'b1;
      end
      // Watchdog keeps timing so static kick repeats every period
      if (!wd_enabled || kick_edge)
        next_st.wd_cnt = '0;
      else if (st.wd_cnt != WDOG_LAST)
        next_st.wd_cnt = st.wd_cnt + 1'b1;
      if (!wd_enabled || kick_edge)
        next_st.wdo_n = 1'b1;
    end
    else if (!wd_enabled)
    begin
      next_st.wdo_n  = 1'b1;
      next_st.wd_cnt = '0;
    end
    else if (kick_edge)
    begin
      next_st.wd_cnt = '0;
      next_st.wdo_n  = 1'b1;
    end
    else if (st.wd_cnt == WDOG_LAST)
    begin
      next_st.wdo_n    = 1'b0;
      next_st.rst_n    = 1'b0;
      next_st.hold_cnt = '0;
      next_st.wd_cnt   = '0;
    end
    else
    begin
      next_st.wd_cnt = st.wd_cnt + 1'b1;
    end
    next_st.rst = ~next_st.rst_n;
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // reset starts low until released by timing
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st          <= '0;
      st.rst_n    <= supervisor_pkg::RST_N_RESET;
      st.rst      <= ~supervisor_pkg::RST_N_RESET;
      st.wdo_n    <= supervisor_pkg::WDO_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_sys_reset_n        = st.rst_n;
  assign o_sys_reset          = st.rst;
  assign o_watchdog_expired_n = st.wdo_n;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  // undervoltage holds reset
  property p_uv_reset;
    @(posedge i_mclk) disable iff (!i_nrst)
    i_supply_low |=> !o_sys_reset_n;
  endproperty
  a_uv_reset: assert property (p_uv_reset)
    else $error("reset not low in undervoltage");

  property p_uv_status;
    @(posedge i_mclk) disable iff (!i_nrst)
    i_supply_low |=> o_watchdog_expired_n;
  endproperty
  a_uv_status: assert property (p_uv_status)
    else $error("status not high in undervoltage");

  property p_complement;
    @(posedge i_mclk) disable iff (!i_nrst)
    o_sys_reset == !o_sys_reset_n;
  endproperty
  a_complement: assert property (p_complement)
    else $error("reset pair not complementary");

  property p_disabled_high;
    @(posedge i_mclk) disable iff (!i_nrst)
    (!kick_valid && !i_supply_low) |=> o_watchdog_expired_n;
  endproperty
  a_disabled_high: assert property (p_disabled_high)
    else $error("status low while disabled");

  property p_kick_clears;
    @(posedge i_mclk) disable iff (!i_nrst)
    kick_edge |=> o_watchdog_expired_n && st.wd_cnt == 0;
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("kick did not restart watchdog");

  property p_stretch;
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_sys_reset_n) |-> $past(st.hold_cnt) == RST_LAST && !$past(i_supply_low);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("reset released early");

  property p_timeout;
    @(posedge i_mclk) disable iff (!i_nrst)
    (o_sys_reset_n && kick_valid && !kick_edge && !i_supply_low && st.wd_cnt == WDOG_LAST)
      |=> !o_watchdog_expired_n && !o_sys_reset_n && st.wd_cnt == 0;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout not signalled");

  property p_no_pulse_disabled;
    @(posedge i_mclk) disable iff (!i_nrst)
    (o_sys_reset_n && !kick_valid && !i_supply_low) |=> o_sys_reset_n;
  endproperty
  a_no_pulse_disabled: assert property (p_no_pulse_disabled)
    else $error("pulse while disabled");

endmodule : supply_supervisor_watchdog

/* supply_supervisor_watchdog_tb.sv */
// Self-checking bench for the supply supervisor and watchdog
`timescale 1ns/10ps
module supply_supervisor_watchdog_tb;
  localparam int RC = 5;   // Short reset pulse keeps the run brief
  localparam int WC = 20;  // Short period, above the host's 16
  logic       i_mclk;          // 50 MHz clock
  logic       i_nrst;          // Reset, active low
  logic       i_supply_low;    // Supply below threshold
  logic [1:0] mode;            // Host kick behaviour
  logic       kick_low;        // Kick valid low
  logic       kick_high;       // Kick valid high
  logic       o_sys_reset_n;   // Reset seen by host
  logic       o_sys_reset;     // Inverse reset
  logic       o_watchdog_expired_n;  // Watchdog status
  int         n_mismatch;      // Mismatches
  int         checked;         // Comparisons
  int         n;               // Cycle tally
  int         m;               // Pulse width tally
  supply_supervisor_watchdog #(.RESET_CYC(RC), .WDOG_CYC(WC)) dut (.i_mclk(i_mclk),
    .i_nrst(i_nrst), .i_supply_low(i_supply_low), .i_kick_low(kick_low),
    .i_kick_high(kick_high), .o_sys_reset_n(o_sys_reset_n), .o_sys_reset(o_sys_reset),
    .o_watchdog_expired_n(o_watchdog_expired_n));
  host_cpu_model host (.i_mclk(i_mclk), .i_mode(mode), .o_kick_low(kick_low),
    .o_kick_high(kick_high));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // Step past edges; the inverse output is watched every cycle
  task automatic cyc(input int k);
    repeat (k)
    begin
      @(posedge i_mclk);
      #1;
      check("sys_reset", o_sys_reset, ~o_sys_reset_n);
    end
  endtask : cyc
  // Bounded wait for reset to go low
  task automatic wait_low(output int c);
    c = 0;
    while (o_sys_reset_n !== 1'h0 && c < 60)
    begin
      cyc(1);
      c++;
    end
  endtask : wait_low
  // Count reset-low cycles over a span
  task automatic lows(input int k, output int c);
    c = 0;
    repeat (k)
    begin
      cyc(1);
      if (o_sys_reset_n !== 1'h1)
        c++;
    end
  endtask : lows
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power;
    cyc(1);
    check("reset_n", o_sys_reset_n, 1'h0);
    check("status", o_watchdog_expired_n, 1'h1);
    cyc(RC + 2);
    check("reset_n", o_sys_reset_n, 1'h1);
    $display("t_power done");
  endtask : t_power
  task automatic t_uv;
    i_supply_low = 1'h1;
    cyc(1);
    check("reset_n", o_sys_reset_n, 1'h0);
    check("status", o_watchdog_expired_n, 1'h1);
    cyc(2);
    i_supply_low = 1'h0;
    cyc(RC - 1);
    check("reset_n", o_sys_reset_n, 1'h0);
    cyc(3);
    check("reset_n", o_sys_reset_n, 1'h1);
    $display("t_uv done");
  endtask : t_uv
  // Kick held high: repeated pulses, then one edge clears status
  task automatic t_static;
    mode = 2'h2;
    wait_low(n);
    check("first", n == WC, 1'h1);
    check("status", o_watchdog_expired_n, 1'h0);
    m = 0;
    while (o_sys_reset_n === 1'h0 && m < WC)
    begin
      cyc(1);
      m++;
    end
    check("width", m >= RC, 1'h1);
    wait_low(n);
    check("period", (m + n) == WC, 1'h1);
    mode = 2'h1;
    cyc(1);
    check("status", o_watchdog_expired_n, 1'h1);
    $display("t_static done");
  endtask : t_static
  // Steady kicking, then a floating kick line
  task automatic t_kick;
    mode = 2'h3;
    cyc(23);
    lows(4 * WC, n);
    check("no_pulse", n == 0, 1'h1);
    mode = 2'h0;
    lows(3 * WC, n);
    check("disabled", n == 0, 1'h1);
    check("status", o_watchdog_expired_n, 1'h1);
    $display("t_kick done");
  endtask : t_kick
  // Timed-out status against restart, floating kick line and undervoltage
  task automatic t_status;
    mode = 2'h2;
    cyc(2);
    mode = 2'h1;
    wait_low(n);
    check("restart", n == WC + 1, 1'h1);
    check("status", o_watchdog_expired_n, 1'h0);
    mode = 2'h0;
    cyc(1);
    check("status", o_watchdog_expired_n, 1'h1);
    mode = 2'h1;
    cyc(RC);
    wait_low(n);
    check("status", o_watchdog_expired_n, 1'h0);
    i_supply_low = 1'h1;
    cyc(1);
    check("reset_n", o_sys_reset_n, 1'h0);
    check("status", o_watchdog_expired_n, 1'h1);
    i_supply_low = 1'h0;
    cyc(RC + 1);
    check("reset_n", o_sys_reset_n, 1'h1);
    $display("t_status done");
  endtask : t_status
  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    i_mclk = 1'h0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Whole run needs some 280 cycles
  initial
  begin
    #40000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    i_nrst = 1'h0;
    i_supply_low = 1'h0;
    mode = 2'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge i_mclk);
    #1 i_nrst = 1'h1;
    t_power;
    t_uv;
    t_static;
    t_kick;
    t_status;
    test_done;
  end
endmodule : supply_supervisor_watchdog_tb
